// File: mco_frame_model.sv
// Behavioural frame engine taking indication requests
`timescale 1ns/1ns
module mco_frame_model (
   // Clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 reset_n,
   // Indication handshake
   input  wire logic                 ind_valid,
   input  wire mco_pkg::mco_ind_type ind_status,
   output logic                      ind_ready,
   // Stall control and record
   input  wire logic                 stall,
   output int                        n_taken,
   output mco_pkg::mco_ind_type      last_status
);
   import mco_pkg::*;
   // Ready follows stall a cycle late, as a busy engine would
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ind_ready   <= 1'b0;
         n_taken     <= 0;
         last_status <= '0;
      end else begin
         ind_ready <= !stall;
         if (ind_valid && ind_ready) begin
            n_taken     <= n_taken + 1;
            last_status <= ind_status;
         end
      end
   end
endmodule

// File: mco_pin_ctrl.sv
// Pin, strap and register control for the fiber media converter function
// Notes on behaviour
// - Thirty-two converter registers sit at indices 0x40 to 0x5F.
// - Two mode straps choose center or terminal operation, default low.
// - Straps 00 switch, 01 center, 10 terminal no port 3, 11 terminal.
// - In terminal mode power-down detect is low active.
// - Falling power-down detect sends indication with power bit one.
// - Fault output low on far fault, partner down or loop-back.
// - Filter strap high drops OAM and errored frames in loop-back.
// - Filter strap low drops only OAM frames in loop-back.
// - Location strap high loops at port 1 PHY, low at port 2 MAC.
// - Loop-back location also lives in register 0x0B bits 3:2.
// - Missing-link strap enables the missing-link feature; the code honours it in the two terminal modes only.
// - Diagnostic change sends indication with S3 equal to new level.
// - PHY register 0 bits 12, 13, 8 control autoneg, speed, duplex.
// - Port register 28 bits 7, 6, 5 control the same settings.
// - Forced flow control from strap or port register 18 bit 4.
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
module mco_pin_ctrl (
   // Clock and reset
   input  wire logic                          ref_clk,
   input  wire logic                          reset_n,
   // APB slave
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [mco_pkg::MCO_ADDR_W-1:0] paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   // Strap pins
   input  wire mco_pkg::mco_strap_type        straps,
   // Live pins
   input  wire logic                          power_down_detect_n,
   input  wire logic                          diagnostic_fail_in,
   input  wire logic                          fiber_signal_detect,
   // Link state from the PHY and OAM logic
   input  wire logic                          far_end_fault,
   input  wire logic                          partner_link_down,
   input  wire logic                          loopback_active,
   // Fault indicator pin
   output logic                               port1_fault_indicator_n,
   // Decoded configuration
   output mco_pkg::mco_mode_type              conv_mode,
   output logic                               port3_enable,
   output logic                               lb_drop_errored,
   output logic [1:0]                         lb_path,
   output logic                               missing_link_on,
   output mco_pkg::mco_port_cfg_type          port1_cfg,
   output logic                               fiber_mode_ok,
   // Indication frame request to the OAM frame engine
   output logic                               ind_valid,
   input  wire logic                          ind_ready,
   output mco_pkg::mco_ind_type               ind_status,
   // Interrupt
   output logic                               irq
);
   import mco_pkg::*;

   // Set wins over clear
   function automatic logic [MCO_IRQ_W-1:0] set_clr(input logic [MCO_IRQ_W-1:0] cur,
                                                    input logic [MCO_IRQ_W-1:0] set,
                                                    input logic [MCO_IRQ_W-1:0] clr);
      set_clr = set | (cur & ~clr);
   endfunction

   // Strap decode to mode
   function automatic mco_mode_type mode_of(input logic hi, input logic lo);
      case ({hi, lo})
         2'b00:   mode_of = MCO_MODE_SWITCH;
         2'b01:   mode_of = MCO_MODE_CENTER;
         2'b10:   mode_of = MCO_MODE_TERM_P3OFF;
         default: mode_of = MCO_MODE_TERM_P3ON;
      endcase
   endfunction

   // Latched straps and register state
   mco_strap_type         strap_r;
   logic                  strap_done_r;
   logic [1:0]            lb_sel_r;
   logic [1:0]            lb_sel_nxt;
   mco_port_cfg_type      cfg_r;
   mco_port_cfg_type      cfg_nxt;
   logic [MCO_IRQ_W-1:0]  irq_stat_r;
   logic [MCO_IRQ_W-1:0]  irq_stat_nxt;
   logic [MCO_IRQ_W-1:0]  irq_mask_r;
   logic                  pdd_prev_r;
   logic                  diag_prev_r;
   logic                  pend_r;
   logic                  pend_nxt;
   mco_ind_type           ind_r;
   logic                  fault_n_r;
   logic                  rd_done_r;
   logic [31:0]           prdata_r;
   logic [7:0]            mem_rdata;

   // Address decode
   // Upper and lowest address bits must be zero, else the access is refused
   wire logic [7:0] idx        = paddr[9:2];
   wire logic       addr_hi_ok = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
   wire logic       hit_oam    = (idx >= MCO_IDX_OAM_LO) && (idx <= MCO_IDX_OAM_HI);
   wire logic       hit_lb     = (idx == MCO_IDX_LBCTL);
   wire logic       hit_p18    = (idx == MCO_IDX_PORT18);
   wire logic       hit_p28    = (idx == MCO_IDX_PORT28);
   wire logic       hit_mii    = (idx == MCO_IDX_MIIM0);
   wire logic       hit_ist    = (idx == MCO_IDX_IRQ_STAT);
   wire logic       hit_imk    = (idx == MCO_IDX_IRQ_MASK);
   wire logic       hit_st     = (idx == MCO_IDX_STATE);
   wire logic       hit_any    = hit_oam | hit_lb | hit_p18 | hit_p28 | hit_mii |
                                 hit_ist | hit_imk | hit_st;
   wire logic       addr_bad   = !(addr_hi_ok && hit_any);

   // Bus strobes
   wire logic       acc        = psel & penable;
   wire logic       wr_ok      = acc & pwrite & ~addr_bad;
   wire logic       rd_first   = acc & ~pwrite & ~rd_done_r;

   // Writes take zero wait states, reads one
   // Refused accesses still complete, flagged by pslverr
   assign pready  = penable & (pwrite | rd_done_r);
   assign pslverr = acc & pready & addr_bad;
   assign prdata  = prdata_r;

   // Mode decode from the held straps
   // An open board comes up as a plain switch
   wire mco_mode_type mode_w   = mode_of(strap_r.mode_select_high,
                                         strap_r.mode_select_low);
   wire logic         terminal = (mode_w == MCO_MODE_TERM_P3OFF) ||
                                 (mode_w == MCO_MODE_TERM_P3ON);

   assign conv_mode       = mode_w;
   assign port3_enable    = (mode_w != MCO_MODE_TERM_P3OFF);
   assign lb_drop_errored = strap_r.loopback_error_filter_strap;
   assign lb_path         = lb_sel_r;
   assign missing_link_on = terminal & strap_r.missing_link_enable;
   assign port1_cfg       = cfg_r;
   // Fiber operation needs detect high and media strap low
   assign fiber_mode_ok   = fiber_signal_detect & ~strap_r.media_select_strap;

   // Pin events in terminal mode only, fault event in every mode
   // Armed only after strap capture, so reset cannot fake an edge
   wire logic ev_armed = strap_done_r & terminal;
   wire logic ev_pdd   = ev_armed & pdd_prev_r & ~power_down_detect_n;
   wire logic ev_diag  = ev_armed & (diag_prev_r != diagnostic_fail_in);
   wire logic ev_any   = ev_pdd | ev_diag;
   wire logic ind_take = pend_r & ind_ready;
   wire logic fault_w  = far_end_fault | partner_link_down | loopback_active;
   wire logic ev_fault = fault_w & fault_n_r;

   assign ind_valid  = pend_r;
   assign ind_status = ind_r;
   assign port1_fault_indicator_n = fault_n_r;
   assign irq        = |(irq_stat_r & irq_mask_r);

   // Indication request: a new event keeps it pending
   always_comb begin
      pend_nxt = ev_any | (pend_r & ~ind_take);
   end

   // Interrupt status, write one to clear
   // A clear in the cycle of a new event loses, so no event is lost
   wire logic [MCO_IRQ_W-1:0] irq_set = {ev_fault, ind_take, ev_diag, ev_pdd};
   wire logic [MCO_IRQ_W-1:0] irq_clr = (wr_ok && hit_ist) ?
                                        pwdata[MCO_IRQ_W-1:0] : MCO_IRQ_RST;
   always_comb begin
      irq_stat_nxt = set_clr(irq_stat_r, irq_set, irq_clr);
   end

   // Loop-back location: strap at capture, software after
   always_comb begin
      lb_sel_nxt = lb_sel_r;
      if (!strap_done_r) begin
         lb_sel_nxt = straps.loopback_location_strap ? MCO_LB_PHY1 : MCO_LB_MAC2;
      end else if (wr_ok && hit_lb) begin
         lb_sel_nxt = pwdata[MCO_LB_LSB +: 2];
      end
   end

   // Port 1 settings share one store seen through three views
   always_comb begin
      cfg_nxt = cfg_r;
      if (!strap_done_r) begin
         cfg_nxt.autoneg     = straps.port1_autoneg_strap;
         cfg_nxt.speed_100   = straps.port1_speed_strap;
         cfg_nxt.full_duplex = straps.port1_duplex_strap;
         cfg_nxt.forced_flow = straps.port1_forced_flow_strap;
      end else if (wr_ok && hit_mii) begin
         cfg_nxt.autoneg     = pwdata[MCO_MII_AN];
         cfg_nxt.speed_100   = pwdata[MCO_MII_SPD];
         cfg_nxt.full_duplex = pwdata[MCO_MII_DPX];
      end else if (wr_ok && hit_p28) begin
         cfg_nxt.autoneg     = pwdata[MCO_P28_AN];
         cfg_nxt.speed_100   = pwdata[MCO_P28_SPD];
         cfg_nxt.full_duplex = pwdata[MCO_P28_DPX];
      end else if (wr_ok && hit_p18) begin
         cfg_nxt.forced_flow = pwdata[MCO_P18_FFC];
      end
   end

   // Read data selection
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_oam) begin
         rd_mux[7:0] = mem_rdata;
      end else if (hit_lb) begin
         rd_mux[MCO_LB_LSB +: 2] = lb_sel_r;
      end else if (hit_p18) begin
         rd_mux[MCO_P18_FFC] = cfg_r.forced_flow;
      end else if (hit_p28) begin
         rd_mux[MCO_P28_AN]  = cfg_r.autoneg;
         rd_mux[MCO_P28_SPD] = cfg_r.speed_100;
         rd_mux[MCO_P28_DPX] = cfg_r.full_duplex;
      end else if (hit_mii) begin
         rd_mux[MCO_MII_AN]  = cfg_r.autoneg;
         rd_mux[MCO_MII_SPD] = cfg_r.speed_100;
         rd_mux[MCO_MII_DPX] = cfg_r.full_duplex;
      end else if (hit_ist) begin
         rd_mux[MCO_IRQ_W-1:0] = irq_stat_r;
      end else if (hit_imk) begin
         rd_mux[MCO_IRQ_W-1:0] = irq_mask_r;
      end else if (hit_st) begin
         rd_mux[7:0] = {mode_w, strap_done_r, fault_n_r, power_down_detect_n,
                        diagnostic_fail_in, pend_r, missing_link_on};
      end
   end

   // Straps captured on the first edge after reset release
   // Later strap changes are ignored until the next reset
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         strap_r      <= '0;
         strap_done_r <= 1'b0;
      end else if (!strap_done_r) begin
         strap_r      <= straps;
         strap_done_r <= 1'b1;
      end
   end

   // Loop-back path register
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         lb_sel_r <= MCO_LB_RST;
      end else begin
         lb_sel_r <= lb_sel_nxt;
      end
   end

   // Port 1 settings, one store behind all views
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_r <= '0;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   // Sticky interrupt status
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_stat_r <= MCO_IRQ_RST;
      end else begin
         irq_stat_r <= irq_stat_nxt;
      end
   end

   // Interrupt mask, software only
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_mask_r <= MCO_IRQ_RST;
      end else if (wr_ok && hit_imk) begin
         irq_mask_r <= pwdata[MCO_IRQ_W-1:0];
      end
   end

   // Pin history, reset to the idle pin levels
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pdd_prev_r  <= 1'b1;
         diag_prev_r <= 1'b0;
      end else begin
         pdd_prev_r  <= power_down_detect_n;
         diag_prev_r <= diagnostic_fail_in;
      end
   end

   // Indication request and its status, latest event wins
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pend_r <= 1'b0;
         ind_r  <= '0;
      end else begin
         pend_r <= pend_nxt;
         if (ev_any) begin
            ind_r.power_s0 <= ~power_down_detect_n;
            ind_r.diag_s3  <= diagnostic_fail_in;
         end
      end
   end

   // Fault indicator, low while any fault holds
   // Registered so the pin never glitches between sources
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         fault_n_r <= 1'b1;
      end else begin
         fault_n_r <= ~fault_w;
      end
   end

   // Read wait state, one cycle for the storage read
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_done_r <= 1'b0;
      end else begin
         rd_done_r <= rd_first;
      end
   end

   // Read data register, held until the next read
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata_r <= 32'h0000_0000;
      end else if (rd_first) begin
         prdata_r <= addr_bad ? 32'h0000_0000 : rd_mux;
      end
   end

   // Converter register storage
   // Read address follows paddr, data ready in the first access cycle
   mco_regmem i_mco_regmem (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .wr_en   (wr_ok & hit_oam),
      .wr_addr (paddr[MCO_OAM_AW+1:2]),
      .wr_data (pwdata[7:0]),
      .rd_addr (paddr[MCO_OAM_AW+1:2]),
      .rd_data (mem_rdata)
   );
endmodule

// File: mco_pin_ctrl_sva.sv
// Assertion checker for the media converter pin control ports
`timescale 1ns/1ns
module mco_pin_ctrl_sva (
   // Clock and reset
   input wire logic                  ref_clk,
   input wire logic                  reset_n,
   // APB
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic                  pready,
   input wire logic                  pslverr,
   // Pins and link state
   input wire logic                  power_down_detect_n,
   input wire logic                  diagnostic_fail_in,
   input wire logic                  far_end_fault,
   input wire logic                  partner_link_down,
   input wire logic                  loopback_active,
   input wire logic                  port1_fault_indicator_n,
   // Mode and indication
   input wire mco_pkg::mco_mode_type conv_mode,
   input wire logic                  port3_enable,
   input wire logic                  ind_valid,
   input wire logic                  ind_ready,
   input wire mco_pkg::mco_ind_type  ind_status
);
   import mco_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // Any fault source
   wire fault_any = far_end_fault | partner_link_down | loopback_active;
   // Properties
   property p_fault_on; fault_any |=> !port1_fault_indicator_n; endproperty
   property p_fault_off; !fault_any |=> port1_fault_indicator_n; endproperty
   property p_port3; port3_enable == (conv_mode != MCO_MODE_TERM_P3OFF); endproperty
   property p_pdd_ind;
      conv_mode[1] && $fell(power_down_detect_n) |=> ind_valid && ind_status.power_s0;
   endproperty
   property p_diag_ind;
      conv_mode[1] && $changed(diagnostic_fail_in)
         |=> ind_valid && (ind_status.diag_s3 == $past(diagnostic_fail_in));
   endproperty
   property p_quiet; !conv_mode[1] && !ind_valid |=> !ind_valid; endproperty
   property p_hold; ind_valid && !ind_ready |=> ind_valid; endproperty
   property p_wr; psel && penable && pwrite |-> pready; endproperty
   property p_rd;
      psel && !penable && !pwrite ##1 psel && penable |-> !pready ##1 pready;
   endproperty
   property p_err; pslverr |-> pready && psel && penable; endproperty
   // Assertions
   a_fault_on: assert property (p_fault_on) else $error("fault indicator not low");
   a_fault_off: assert property (p_fault_off) else $error("fault indicator not high");
   a_port3: assert property (p_port3) else $error("port 3 enable wrong");
   a_pdd_ind: assert property (p_pdd_ind) else $error("no power indication");
   a_diag_ind: assert property (p_diag_ind) else $error("no diagnostic indication");
   a_quiet: assert property (p_quiet) else $error("indication outside terminal mode");
   a_hold: assert property (p_hold) else $error("indication dropped");
   a_wr: assert property (p_wr) else $error("write not ready");
   a_rd: assert property (p_rd) else $error("read wait wrong");
   a_err: assert property (p_err) else $error("error outside access");
   // Main scenarios
   c_ind: cover property (ind_valid && ind_ready);
   c_fault: cover property (!port1_fault_indicator_n);
   c_err: cover property (pslverr);
endmodule

bind mco_pin_ctrl mco_pin_ctrl_sva i_mco_pin_ctrl_sva (.ref_clk, .reset_n, .psel, .penable,
   .pwrite, .pready, .pslverr, .power_down_detect_n, .diagnostic_fail_in, .far_end_fault,
   .partner_link_down, .loopback_active, .port1_fault_indicator_n, .conv_mode, .port3_enable,
   .ind_valid, .ind_ready, .ind_status);

// File: mco_pin_ctrl_tb.sv
// Self-checking bench for the media converter pin control block
`timescale 1ns/1ns
module mco_pin_ctrl_tb;
   import mco_pkg::*;
   logic             ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, err;
   logic             power_down_detect_n, diagnostic_fail_in, fiber_signal_detect, stall;
   logic             far_end_fault, partner_link_down, loopback_active, port1_fault_indicator_n;
   logic             port3_enable, lb_drop_errored, missing_link_on, fiber_mode_ok;
   logic             ind_valid, ind_ready;
   logic [11:0]      paddr;
   logic [31:0]      pwdata, prdata, rd;
   logic [1:0]       lb_path, m;
   mco_strap_type    straps, s;
   mco_mode_type     conv_mode;
   mco_port_cfg_type port1_cfg;
   mco_ind_type      ind_status, last_st;
   int               n_taken, n_fail, check_count, n0;

   mco_pin_ctrl i_mco_pin_ctrl (.ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .straps, .power_down_detect_n, .diagnostic_fail_in,
      .fiber_signal_detect, .far_end_fault, .partner_link_down, .loopback_active,
      .port1_fault_indicator_n, .conv_mode, .port3_enable, .lb_drop_errored, .lb_path,
      .missing_link_on, .port1_cfg, .fiber_mode_ok, .ind_valid, .ind_ready, .ind_status, .irq);
   mco_frame_model i_mco_frame_model (.ref_clk, .reset_n, .ind_valid, .ind_status, .ind_ready,
      .stall, .n_taken, .last_status(last_st));

   // Clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Compare and count
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task wrap_up;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // Reset with the given straps held for 16 cycles
   task rst(input mco_strap_type v);
      @(posedge ref_clk);
      reset_n <= 1'b0;
      straps <= v;
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      tick(3);
   endtask

   // One APB transfer; read data and error taken at the ready edge
   task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      int k;
      logic rdy;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         #1;
         rdy = (pready === 1'b1);
         rd = prdata;
         err = pslverr;
         @(posedge ref_clk);
         k++;
      end while (!rdy && k < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (!rdy) begin
         n_fail++;
         wrap_up();
      end
   endtask

   initial begin
      {psel, penable, pwrite, paddr, pwdata, straps} = '0;
      {reset_n, diagnostic_fail_in, far_end_fault, partner_link_down, loopback_active} = '0;
      {power_down_detect_n, fiber_signal_detect, stall} = 3'b110;
      {n_fail, check_count} = '0;
      // Every mode with its strap set
      for (int i = 0; i < 4; i++) begin
         m = i[1:0];
         s = '0;
         {s.mode_select_high, s.mode_select_low} = m;
         s.loopback_error_filter_strap = m[0];
         s.loopback_location_strap = m[1];
         s.missing_link_enable = m[0];
         s.port1_autoneg_strap = (m == 2'b10);
         s.media_select_strap = m[0];
         s.port1_speed_strap = m[0];
         s.port1_duplex_strap = 1'b1;
         s.port1_forced_flow_strap = m[1];
         rst(s);
         chk(conv_mode, m);
         chk(port3_enable, m != 2'b10);
         chk(lb_drop_errored, m[0]);
         chk(lb_path, {1'b0, m[1]});
         chk(missing_link_on, m[1] & m[0]);
         chk(fiber_mode_ok, !m[0]);
         chk(port1_cfg, {m == 2'b10, m[0], 1'b1, m[1]});
         apb(1'b0, MCO_IDX_LBCTL, 32'h0);
         chk(rd[3:2], {1'b0, m[1]});
         apb(1'b0, MCO_IDX_PORT28, 32'h0);
         chk(rd[7:5], {m == 2'b10, m[0], 1'b1});
         @(posedge ref_clk) diagnostic_fail_in <= 1'b1;
         tick(3);
         chk(n_taken, m[1]);
         chk(last_st.diag_s3, m[1]);
         @(posedge ref_clk) diagnostic_fail_in <= 1'b0;
         tick(3);
         chk(n_taken, {m[1], 1'b0});
         @(posedge ref_clk) {straps, fiber_signal_detect} <= {~s, m[0]};
         tick(2);
         chk({conv_mode, lb_drop_errored, fiber_mode_ok}, {m, m[0], 1'b0});
      end
      // Converter storage, upper bits dropped, unmapped refused
      apb(1'b1, MCO_IDX_OAM_LO, 32'hFFFF_FFA5);
      apb(1'b1, MCO_IDX_OAM_HI, 32'h0000_005A);
      apb(1'b0, MCO_IDX_OAM_LO, 32'h0);
      chk(rd, 32'h0000_00A5);
      apb(1'b0, MCO_IDX_OAM_HI, 32'h0);
      chk(rd, 32'h0000_005A);
      apb(1'b0, 8'h60, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      // Software loop-back path and port settings
      apb(1'b1, MCO_IDX_LBCTL, 32'h0000_0008);
      tick(1);
      chk(lb_path, 2'b10);
      apb(1'b1, MCO_IDX_PORT28, 32'h0000_0080);
      apb(1'b0, MCO_IDX_MIIM0, 32'h0);
      chk({rd[13], rd[12], rd[8]}, 3'b010);
      apb(1'b1, MCO_IDX_MIIM0, 32'h0000_2100);
      tick(1);
      chk(port1_cfg[3:1], 3'b011);
      for (int v = 0; v < 2; v++) begin
         apb(1'b1, MCO_IDX_PORT18, v ? 32'h0000_0010 : 32'h0);
         tick(1);
         chk(port1_cfg.forced_flow, v[0]);
      end
      // Power-down indication against a stalled engine, masked then unmasked
      apb(1'b1, MCO_IDX_IRQ_MASK, 32'h0);
      @(posedge ref_clk) stall <= 1'b1;
      tick(2);
      @(posedge ref_clk) power_down_detect_n <= 1'b0;
      tick(2);
      chk({ind_valid, ind_status}, 3'b110);
      chk(irq, 1'b0);
      apb(1'b0, MCO_IDX_IRQ_STAT, 32'h0);
      chk(rd[0], 1'b1);
      n0 = n_taken;
      @(posedge ref_clk) stall <= 1'b0;
      tick(4);
      chk(n_taken, n0 + 1);
      chk({ind_valid, last_st.power_s0}, 2'b01);
      apb(1'b1, MCO_IDX_IRQ_MASK, 32'h0000_0001);
      tick(1);
      chk(irq, 1'b1);
      apb(1'b1, MCO_IDX_IRQ_STAT, 32'h0000_0001);
      tick(1);
      chk(irq, 1'b0);
      @(posedge ref_clk) power_down_detect_n <= 1'b1;
      tick(3);
      chk(n_taken, n0 + 1);
      // Each fault source pulls the indicator low
      for (int k = 0; k < 3; k++) begin
         @(posedge ref_clk) {far_end_fault, partner_link_down, loopback_active} <= 3'b001 << k;
         tick(2);
         chk(port1_fault_indicator_n, 1'b0);
         @(posedge ref_clk) {far_end_fault, partner_link_down, loopback_active} <= 3'b000;
         tick(2);
         chk(port1_fault_indicator_n, 1'b1);
      end
      wrap_up();
   end
endmodule

// File: mco_pkg.sv
// Shared constants and types for the media converter pin and strap control block
package mco_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] MCO_IDX_LBCTL    = 8'h0B;
   localparam logic [7:0] MCO_IDX_PORT18   = 8'h12;
   localparam logic [7:0] MCO_IDX_PORT28   = 8'h1C;
   localparam logic [7:0] MCO_IDX_MIIM0    = 8'h20;
   localparam logic [7:0] MCO_IDX_IRQ_STAT = 8'h30;
   localparam logic [7:0] MCO_IDX_IRQ_MASK = 8'h31;
   localparam logic [7:0] MCO_IDX_STATE    = 8'h32;
   localparam logic [7:0] MCO_IDX_OAM_LO   = 8'h40;
   localparam logic [7:0] MCO_IDX_OAM_HI   = 8'h5F;
   localparam int         MCO_OAM_WORDS    = 32;
   localparam int         MCO_OAM_AW       = 5;
   localparam int         MCO_ADDR_W       = 12;
   // Field positions
   localparam int MCO_LB_LSB    = 2;
   localparam int MCO_P28_AN    = 7;
   localparam int MCO_P28_SPD   = 6;
   localparam int MCO_P28_DPX   = 5;
   localparam int MCO_P18_FFC   = 4;
   localparam int MCO_MII_AN    = 12;
   localparam int MCO_MII_SPD   = 13;
   localparam int MCO_MII_DPX   = 8;
   // Interrupt status bit positions
   localparam int MCO_IRQ_PDD   = 0;
   localparam int MCO_IRQ_DIAG  = 1;
   localparam int MCO_IRQ_SENT  = 2;
   localparam int MCO_IRQ_FAULT = 3;
   localparam int MCO_IRQ_W     = 4;
   // Loop-back turn-around points
   localparam logic [1:0] MCO_LB_MAC2 = 2'b00;
   localparam logic [1:0] MCO_LB_PHY1 = 2'b01;
   localparam logic [1:0] MCO_LB_UTP2 = 2'b10;
   // Reset values
   localparam logic [1:0]        MCO_LB_RST   = 2'b00;
   localparam logic [MCO_IRQ_W-1:0] MCO_IRQ_RST = 4'h0;

   typedef enum logic [1:0] {
      MCO_MODE_SWITCH,
      MCO_MODE_CENTER,
      MCO_MODE_TERM_P3OFF,
      MCO_MODE_TERM_P3ON
   } mco_mode_type;

   typedef struct packed {
      logic mode_select_high;
      logic mode_select_low;
      logic loopback_error_filter_strap;
      logic loopback_location_strap;
      logic missing_link_enable;
      logic media_select_strap;
      logic port1_autoneg_strap;
      logic port1_speed_strap;
      logic port1_duplex_strap;
      logic port1_forced_flow_strap;
   } mco_strap_type;

   typedef struct packed {
      logic autoneg;
      logic speed_100;
      logic full_duplex;
      logic forced_flow;
   } mco_port_cfg_type;

   // Status bits carried by an indication frame
   typedef struct packed {
      logic power_s0;
      logic diag_s3;
   } mco_ind_type;
endpackage

// File: mco_regmem.sv
// Register storage for the converter register range, registered read data
`timescale 1ns/1ns
module mco_regmem (
   // Clock and reset
   input  wire logic                          ref_clk,
   input  wire logic                          reset_n,
   // Write port
   input  wire logic                          wr_en,
   input  wire logic [mco_pkg::MCO_OAM_AW-1:0] wr_addr,
   input  wire logic [7:0]                    wr_data,
   // Read port
   input  wire logic [mco_pkg::MCO_OAM_AW-1:0] rd_addr,
   output logic      [7:0]                    rd_data
);
   import mco_pkg::*;

   logic [7:0] mem [MCO_OAM_WORDS];

   // Write storage
   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Read one cycle after the address
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule
